// [logic/adc_ctrl_cfg.svh]
// Purpose: Constants for the converter host control port.
// Assumes: Core clock of 20 MHz; tick counts are in master clock ticks, the idle and divider limits in core cycles.
// Notes: Field positions of the status byte live here too.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define RES_BITS 12
`define RES_MSB 11
`define CORE_PERIOD_NS 50
`define RST_MIN_NS 100
`define RST_MIN_CYCLES ((`RST_MIN_NS + `CORE_PERIOD_NS - 1) / `CORE_PERIOD_NS)
`define CAL_RESET_TICKS 58280
`define CAL_CNT_W 16
`define TICK_CNT_W 7
`define CONV_TICKS 7'h34
`define TRACK_TICKS 7'h0C
`define LOOP_TICKS 7'h40
`define ILV_EXTRA_TICKS 7'h14
`define ILV_CAL_CONVS 11'h7DE
`define ILV_CNT_W 11
`define EXT_IDLE_LIMIT 4'hF
`define INT_DIV_LAST 3'h4
`define STS_BUSY 0
`define STS_CAL 1
`define STS_BURST 2
`define STS_ILV 3
`define STS_BYTE_LO 4
`define STS_TRACKED 5
`define STS_PASS 6
`define STS_VALID 7

`endif

// [logic/adc_ctrl_pkg.sv]
// Purpose: Types shared by the converter host control port.
// Assumes: Nothing beyond the configuration header.
// Notes: Holds the sequencer state type only.
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_CAL_RESET,
        ST_TRACK,
        ST_CONVERT,
        ST_CAL_BURST
    } state_e;
endpackage : adc_ctrl_pkg

// [logic/adc_host_control_port.sv]
// Purpose: Host control and readout port of a self-calibrating converter.
// Assumes: Host pins are synchronous to CORE_CLK_I; SAMPLE_I is the held front-end value.
// Notes: Output enables are high while the data bus is driven.
//
// Behaviour
// - Falling hold strobe enters hold and starts a conversion.
// - Chip select high: bus released, calibration request inputs ignored.
// - Requests latched at chip select rise; next fall starts or ends calibration.
// - Bus driven only while read and chip select are both low.
// - Read select high gives data, low gives status.
// - Polarity high gives offset binary, low gives straight binary.
// - Polarity may change any time after calibration without recalibrating.
// - Master reset high resets the sequencer, request latches and handshake outputs, not the bus or clock logic; host holds it 100 ns.
// - Master reset falling starts a full calibration.
// - Full bus width presents all twelve result bits at once.
// - Byte mode: high byte first, then low nibble plus zeros, alternating.
// - Status always on the low byte lanes whatever the width.
// - Interleave mode: full pass every 2014 conversions, conversions 20 ticks longer.
// - Reset calibration takes 58280 master clock ticks.
// - Conversion done falls at the end of reset calibration.
// - Loopback acquires and converts each sample in 64 master ticks, 84 in interleave mode.
// - Read select low with chip select and hold low is a software reset.
// - Burst request starts burst calibration; low request with hold high stops it.
// - Timing from master clock pin, or internal oscillator when pin is idle.
// - Burst calibration waits for a running conversion; no conversions while calibrating.
// - Conversion done high while converting, falls on data, rises on read or start.
// - Track done falls once the input has had time to be acquired.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"

module adc_host_control_port #(
    parameter int CAL_RESET_TICKS = `CAL_RESET_TICKS
) (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic MASTER_RESET_I,
    input wire logic MASTER_CLOCK_IN_I,
    input wire logic HOLD_N_I,
    input wire logic CS_N_I,
    input wire logic RD_N_I,
    input wire logic READ_SELECT_I,
    input wire logic BUS_WIDTH_SELECT_I,
    input wire logic POLARITY_SELECT_I,
    input wire logic BURST_CAL_REQUEST_I,
    input wire logic INTERLEAVE_CAL_REQUEST_I,
    input wire logic LOOPBACK_I,
    input wire logic [`RES_MSB:0] SAMPLE_I,
    output logic [`RES_MSB:0] DATA_O,
    output logic DATA_OE_O,
    output logic CONV_DONE_N_O,
    output logic TRACK_DONE_N_O,
    output logic CAL_ACTIVE_O
);

    adc_ctrl_pkg::state_e state_q;
    logic dev_rst;
    logic soft_rst;
    logic ext_prev_q;
    logic ext_rise;
    logic [3:0] idle_cnt_q;
    logic [2:0] div_q;
    logic tick_q;
    logic hold_prev_q;
    logic cs_prev_q;
    logic read_prev_q;
    logic read_act;
    logic hold_fall;
    logic cs_fall;
    logic read_end;
    logic rd_sel_q;
    logic burst_lat_q;
    logic ilv_lat_q;
    logic burst_pend_q;
    logic burst_stop_q;
    logic ilv_mode_q;
    logic [`CAL_CNT_W-1:0] cal_cnt_q;
    logic [`TICK_CNT_W-1:0] tcnt_q;
    logic [`TICK_CNT_W-1:0] conv_len;
    logic [`ILV_CNT_W-1:0] ilv_cnt_q;
    logic ilv_pass_q;
    logic [`RES_MSB:0] held_q;
    logic [`RES_MSB:0] result_q;
    logic [`RES_MSB:0] enc;
    logic [7:0] status;
    logic [`RES_MSB:0] bus_d;
    logic byte_lo_q;
    logic tracked;
    logic conv_start;
    logic conv_end;
    logic cal_end;

    // A read-select-low read while hold and chip select are low is a reset, not a status read.
    assign soft_rst = !HOLD_N_I && !CS_N_I && !READ_SELECT_I;
    assign dev_rst = !RST_N_I || MASTER_RESET_I || soft_rst;

    // Master clock source selection.
    assign ext_rise = MASTER_CLOCK_IN_I && !ext_prev_q;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            ext_prev_q <= 1'b0;
            idle_cnt_q <= `EXT_IDLE_LIMIT;
            div_q <= 3'h0;
            tick_q <= 1'b0;
        end else begin
            ext_prev_q <= MASTER_CLOCK_IN_I;
            if (ext_rise) begin
                idle_cnt_q <= 4'h0;
            end else if (idle_cnt_q != `EXT_IDLE_LIMIT) begin
                idle_cnt_q <= idle_cnt_q + 4'h1;
            end
            div_q <= (div_q == `INT_DIV_LAST) ? 3'h0 : div_q + 3'h1;
            // A grounded pin never toggles, so the internal divider takes over.
            if (idle_cnt_q != `EXT_IDLE_LIMIT) begin
                tick_q <= ext_rise;
            end else begin
                tick_q <= (div_q == `INT_DIV_LAST);
            end
        end
    end

    // Host strobe edges.
    assign read_act = !CS_N_I && !RD_N_I;
    assign hold_fall = hold_prev_q && !HOLD_N_I;
    assign cs_fall = cs_prev_q && !CS_N_I;
    assign read_end = read_prev_q && !read_act;

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            hold_prev_q <= 1'b1;
            cs_prev_q <= 1'b1;
            read_prev_q <= 1'b0;
            rd_sel_q <= 1'b0;
        end else begin
            hold_prev_q <= HOLD_N_I;
            cs_prev_q <= CS_N_I;
            read_prev_q <= read_act;
            if (read_act) begin
                rd_sel_q <= READ_SELECT_I;
            end
        end
    end

    // The latches follow the pins only while selected, so the value frozen at the rise
    // of chip select is what the next fall acts on.
    always_ff @(posedge CORE_CLK_I) begin
        if (dev_rst) begin
            burst_lat_q <= 1'b0;
            ilv_lat_q <= 1'b1;
            burst_pend_q <= 1'b0;
            burst_stop_q <= 1'b0;
            ilv_mode_q <= 1'b0;
        end else begin
            if (!CS_N_I) begin
                burst_lat_q <= BURST_CAL_REQUEST_I;
                ilv_lat_q <= INTERLEAVE_CAL_REQUEST_I;
            end
            if (cs_fall) begin
                ilv_mode_q <= !ilv_lat_q;
            end
            if (cs_fall && burst_lat_q) begin
                burst_pend_q <= 1'b1;
            end else if (state_q == adc_ctrl_pkg::ST_CAL_BURST) begin
                burst_pend_q <= 1'b0;
            end
            if (cs_fall && !burst_lat_q && HOLD_N_I) begin
                burst_stop_q <= 1'b1;
            end else if (state_q != adc_ctrl_pkg::ST_CAL_BURST || burst_pend_q) begin
                burst_stop_q <= 1'b0;
            end
        end
    end

    assign conv_len = ilv_mode_q ? `CONV_TICKS + `ILV_EXTRA_TICKS : `CONV_TICKS;
    assign tracked = (state_q == adc_ctrl_pkg::ST_TRACK) && (tcnt_q >= `TRACK_TICKS);
    // Track length plus conversion length make up one loopback period.
    assign conv_start = (state_q == adc_ctrl_pkg::ST_TRACK) && !burst_pend_q
        && (hold_fall || (LOOPBACK_I && tracked));
    assign conv_end = (state_q == adc_ctrl_pkg::ST_CONVERT) && tick_q
        && (tcnt_q == conv_len - `TICK_CNT_W'(1));
    assign cal_end = (state_q == adc_ctrl_pkg::ST_CAL_RESET) && tick_q
        && (cal_cnt_q == `CAL_CNT_W'(CAL_RESET_TICKS - 1));

    // Conversion and calibration sequencer.
    always_ff @(posedge CORE_CLK_I) begin
        if (dev_rst) begin
            state_q <= adc_ctrl_pkg::ST_CAL_RESET;
            cal_cnt_q <= '0;
            tcnt_q <= '0;
        end else begin
            case (state_q)
                adc_ctrl_pkg::ST_CAL_RESET: begin
                    if (cal_end) begin
                        state_q <= adc_ctrl_pkg::ST_TRACK;
                        cal_cnt_q <= '0;
                        tcnt_q <= '0;
                    end else if (tick_q) begin
                        cal_cnt_q <= cal_cnt_q + `CAL_CNT_W'(1);
                    end
                end
                adc_ctrl_pkg::ST_TRACK: begin
                    if (burst_pend_q) begin
                        state_q <= adc_ctrl_pkg::ST_CAL_BURST;
                    end else if (conv_start) begin
                        state_q <= adc_ctrl_pkg::ST_CONVERT;
                        tcnt_q <= '0;
                    end else if (tick_q && !tracked) begin
                        tcnt_q <= tcnt_q + `TICK_CNT_W'(1);
                    end
                end
                adc_ctrl_pkg::ST_CONVERT: begin
                    // Hold edges are ignored here; burst calibration starts wait until the result is in.
                    if (conv_end) begin
                        state_q <= adc_ctrl_pkg::ST_TRACK;
                        tcnt_q <= '0;
                    end else if (tick_q) begin
                        tcnt_q <= tcnt_q + `TICK_CNT_W'(1);
                    end
                end
                adc_ctrl_pkg::ST_CAL_BURST: begin
                    if (burst_stop_q) begin
                        state_q <= adc_ctrl_pkg::ST_TRACK;
                        tcnt_q <= '0;
                    end else if (tick_q) begin
                        // Burst passes resume where the last one stopped.
                        cal_cnt_q <= (cal_cnt_q == `CAL_CNT_W'(CAL_RESET_TICKS - 1))
                            ? '0 : cal_cnt_q + `CAL_CNT_W'(1);
                    end
                end
                default: begin
                    state_q <= adc_ctrl_pkg::ST_CAL_RESET;
                end
            endcase
        end
    end

    // Sample capture, result and interleave pass counting.
    always_ff @(posedge CORE_CLK_I) begin
        if (dev_rst) begin
            held_q <= '0;
            result_q <= '0;
            ilv_cnt_q <= '0;
            ilv_pass_q <= 1'b0;
        end else begin
            if (conv_start) begin
                held_q <= SAMPLE_I;
            end
            if (conv_end) begin
                result_q <= held_q;
                if (ilv_mode_q) begin
                    if (ilv_cnt_q == `ILV_CAL_CONVS - `ILV_CNT_W'(1)) begin
                        ilv_cnt_q <= '0;
                        ilv_pass_q <= !ilv_pass_q;
                    end else begin
                        ilv_cnt_q <= ilv_cnt_q + `ILV_CNT_W'(1);
                    end
                end
            end
        end
    end

    // Handshake outputs; a falling edge from new data wins over a read in the same cycle.
    always_ff @(posedge CORE_CLK_I) begin
        if (dev_rst) begin
            CONV_DONE_N_O <= 1'b1;
            TRACK_DONE_N_O <= 1'b1;
            CAL_ACTIVE_O <= 1'b1;
            byte_lo_q <= 1'b0;
        end else begin
            if (read_end || conv_start || burst_pend_q) begin
                CONV_DONE_N_O <= 1'b1;
            end
            if (conv_end || cal_end
                || (burst_stop_q && state_q == adc_ctrl_pkg::ST_CAL_BURST)) begin
                CONV_DONE_N_O <= 1'b0;
            end
            TRACK_DONE_N_O <= !tracked;
            CAL_ACTIVE_O <= (state_q == adc_ctrl_pkg::ST_CAL_RESET)
                || (state_q == adc_ctrl_pkg::ST_CAL_BURST);
            if (conv_end) begin
                byte_lo_q <= 1'b0;
            end else if (read_end && rd_sel_q && !BUS_WIDTH_SELECT_I) begin
                byte_lo_q <= !byte_lo_q;
            end
        end
    end

    // Encoding is applied at read time, so the polarity pin can move freely.
    always_comb begin
        if (POLARITY_SELECT_I) begin
            enc = {!result_q[`RES_MSB], result_q[`RES_MSB-1:0]};
        end else if (result_q[`RES_MSB]) begin
            enc = '0;
        end else begin
            enc = {result_q[`RES_MSB-1:0], 1'b0};
        end
    end

    always_comb begin
        status = 8'h00;
        status[`STS_BUSY] = (state_q == adc_ctrl_pkg::ST_CONVERT);
        status[`STS_CAL] = CAL_ACTIVE_O;
        status[`STS_BURST] = burst_pend_q || (state_q == adc_ctrl_pkg::ST_CAL_BURST);
        status[`STS_ILV] = ilv_mode_q;
        status[`STS_BYTE_LO] = byte_lo_q;
        status[`STS_TRACKED] = !TRACK_DONE_N_O;
        status[`STS_PASS] = ilv_pass_q;
        status[`STS_VALID] = !CONV_DONE_N_O;
    end

    always_comb begin
        if (!READ_SELECT_I) begin
            bus_d = {4'h0, status};
        end else if (BUS_WIDTH_SELECT_I) begin
            bus_d = enc;
        end else if (!byte_lo_q) begin
            bus_d = {4'h0, enc[`RES_MSB:4]};
        end else begin
            bus_d = {4'h0, enc[3:0], 4'h0};
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            DATA_O <= '0;
            DATA_OE_O <= 1'b0;
        end else begin
            DATA_O <= bus_d;
            DATA_OE_O <= read_act;
        end
    end

    property p_bus_enable;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        ##1 (DATA_OE_O == $past(!CS_N_I && !RD_N_I));
    endproperty
    a_bus_enable: assert property (p_bus_enable) else $error("Bus enable wrong.");

    property p_cs_release;
        @(posedge CORE_CLK_I) disable iff (dev_rst)
        CS_N_I |=> !DATA_OE_O && $stable(burst_lat_q) && $stable(ilv_lat_q);
    endproperty
    a_cs_release: assert property (p_cs_release) else $error("Deselected port acted.");

    property p_hold_start;
        @(posedge CORE_CLK_I) disable iff (dev_rst)
        (hold_fall && state_q == adc_ctrl_pkg::ST_TRACK && !burst_pend_q)
            |=> state_q == adc_ctrl_pkg::ST_CONVERT ##1 CONV_DONE_N_O;
    endproperty
    a_hold_start: assert property (p_hold_start) else $error("Hold did not convert.");

    property p_reset_cal;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        $fell(MASTER_RESET_I) |-> state_q == adc_ctrl_pkg::ST_CAL_RESET && cal_cnt_q == '0;
    endproperty
    a_reset_cal: assert property (p_reset_cal) else $error("No calibration after reset.");

    property p_soft_reset;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        soft_rst |=> state_q == adc_ctrl_pkg::ST_CAL_RESET && CONV_DONE_N_O;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset missed.");

    property p_cal_done;
        @(posedge CORE_CLK_I) disable iff (dev_rst)
        (state_q == adc_ctrl_pkg::ST_CAL_RESET && tick_q
            && cal_cnt_q == `CAL_CNT_W'(CAL_RESET_TICKS - 1))
            |=> state_q == adc_ctrl_pkg::ST_TRACK && !CONV_DONE_N_O;
    endproperty
    a_cal_done: assert property (p_cal_done) else $error("Reset cal end wrong.");

    property p_status_low;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (read_act && !READ_SELECT_I) |=> DATA_O[`RES_MSB:8] == 4'h0;
    endproperty
    a_status_low: assert property (p_status_low) else $error("Status not on low lanes.");

    property p_byte_high;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        (READ_SELECT_I && !BUS_WIDTH_SELECT_I && !byte_lo_q)
            |=> DATA_O == {4'h0, $past(enc[`RES_MSB:4])};
    endproperty
    a_byte_high: assert property (p_byte_high) else $error("High byte wrong.");

    property p_bipolar;
        @(posedge CORE_CLK_I) disable iff (!RST_N_I)
        POLARITY_SELECT_I |-> enc[`RES_MSB] != result_q[`RES_MSB];
    endproperty
    a_bipolar: assert property (p_bipolar) else $error("Offset binary wrong.");

    property p_no_conv_in_cal;
        @(posedge CORE_CLK_I) disable iff (dev_rst)
        (state_q == adc_ctrl_pkg::ST_CAL_BURST && !burst_stop_q)
            |=> state_q != adc_ctrl_pkg::ST_CONVERT;
    endproperty
    a_no_conv_in_cal: assert property (p_no_conv_in_cal) else $error("Converted in cal.");

endmodule : adc_host_control_port

// [testbench/host_port_model.sv]
// Purpose: Host side model that drives the converter control and read pins.
// Assumes: Pins change on the falling core clock edge only.
// Notes: Hold stays high outside strobes, so a status read never turns into a soft reset.
`timescale 1ns/1ps
module host_port_model (
    input wire logic clk_i,
    input wire logic data_oe_i,
    input wire logic [11:0] data_i,
    output logic hold_n_o,
    output logic cs_n_o,
    output logic rd_n_o,
    output logic read_select_o,
    output logic burst_o,
    output logic ilv_req_o
);
    initial begin
        hold_n_o = 1'b1;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        read_select_o = 1'b1;
        burst_o = 1'b0;
        ilv_req_o = 1'b1;
    end

    // Seven core cycles cover one master tick plus more than 50 ns.
    task automatic strobe_hold();
        @(negedge clk_i);
        hold_n_o = 1'b0;
        repeat (7) @(negedge clk_i);
        hold_n_o = 1'b1;
    endtask : strobe_hold

    // Read select is only lowered while hold is high.
    task automatic bus_read(input logic sel, input logic cs, output logic [11:0] val,
                            output logic oe);
        @(negedge clk_i);
        read_select_o = sel;
        cs_n_o = cs;
        rd_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        val = data_i;
        oe = data_oe_i;
        rd_n_o = 1'b1;
        cs_n_o = 1'b1;
        read_select_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask : bus_read

    // Burst requests are used to prove both the start and the stop paths work.
    task automatic cal_request(input logic burst, input logic ilv);
        @(negedge clk_i);
        cs_n_o = 1'b0;
        burst_o = burst;
        ilv_req_o = ilv;
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b0;
        repeat (2) @(negedge clk_i);
        cs_n_o = 1'b1;
        repeat (2) @(negedge clk_i);
    endtask : cal_request

    task automatic soft_reset();
        @(negedge clk_i);
        hold_n_o = 1'b0;
        cs_n_o = 1'b0;
        read_select_o = 1'b0;
        repeat (3) @(negedge clk_i);
        hold_n_o = 1'b1;
        cs_n_o = 1'b1;
        read_select_o = 1'b1;
    endtask : soft_reset
endmodule : host_port_model

// [testbench/adc_host_control_port_tb.sv]
// Purpose: Self-checking bench for the converter host control port.
// Assumes: Internal master tick every 5 core cycles; external clock period of 4 core cycles.
// Notes: Latencies are checked within two ticks, since the tick phase is not visible.
`timescale 1ns/1ps
`include "adc_ctrl_cfg.svh"
module adc_host_control_port_tb;
    localparam int CAL_TICKS = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic mrst = 1'b0;
    logic mclk = 1'b0;
    logic ext_en = 1'b0;
    logic [1:0] ext_cnt = 2'h0;
    logic loopback = 1'b0;
    logic wide_bus = 1'b1;
    logic pol = 1'b1;
    logic [11:0] sample = 12'h000;
    logic hold_n, cs_n, rd_n, rs, burst, ilv_req;
    logic [11:0] data;
    logic data_oe, conv_done_n, track_done_n, cal_active;
    logic [11:0] val;
    logic oe;
    int n, m, fail_count = 0, total_checks = 0;

    always #25 clk = ~clk;
    always @(negedge clk) begin
        ext_cnt <= ext_en ? ext_cnt + 2'h1 : 2'h0;
        mclk <= ext_en & ext_cnt[1];
    end

    adc_host_control_port #(.CAL_RESET_TICKS(CAL_TICKS)) u_adc_host_control_port (
        .CORE_CLK_I(clk), .RST_N_I(rst_n), .MASTER_RESET_I(mrst), .MASTER_CLOCK_IN_I(mclk),
        .HOLD_N_I(hold_n), .CS_N_I(cs_n), .RD_N_I(rd_n), .READ_SELECT_I(rs),
        .BUS_WIDTH_SELECT_I(wide_bus), .POLARITY_SELECT_I(pol), .BURST_CAL_REQUEST_I(burst),
        .INTERLEAVE_CAL_REQUEST_I(ilv_req), .LOOPBACK_I(loopback), .SAMPLE_I(sample),
        .DATA_O(data), .DATA_OE_O(data_oe), .CONV_DONE_N_O(conv_done_n),
        .TRACK_DONE_N_O(track_done_n), .CAL_ACTIVE_O(cal_active));

    host_port_model u_host_port_model (
        .clk_i(clk), .data_oe_i(data_oe), .data_i(data), .hold_n_o(hold_n), .cs_n_o(cs_n),
        .rd_n_o(rd_n), .read_select_o(rs), .burst_o(burst), .ilv_req_o(ilv_req));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic wait_lvl(input logic lvl, output int cnt);
        cnt = 0;
        while (conv_done_n !== lvl && cnt < 3000) begin
            @(negedge clk);
            cnt++;
        end
        if (cnt >= 3000) check({11'h0, conv_done_n}, {11'h0, lvl});
    endtask : wait_lvl

    // Tick phase is unknown, so a span is accepted within two ticks of nominal.
    function automatic logic [11:0] in_span(input int cyc, input int ticks, input int per);
        return {11'h0, (cyc >= (ticks - 2) * per) && (cyc <= (ticks + 2) * per)};
    endfunction : in_span

    function automatic logic [11:0] enc(input logic p, input logic [11:0] s);
        if (p) return s ^ 12'h800;
        return s[11] ? 12'h000 : {s[10:0], 1'b0};
    endfunction : enc

    task automatic convert(input int ticks, input int per);
        u_host_port_model.strobe_hold();
        check({11'h0, conv_done_n}, 12'h001);
        check({11'h0, track_done_n}, 12'h001);
        wait_lvl(1'b0, n);
        check(in_span(n + 7, ticks, per), 12'h001);
    endtask : convert

    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        check({11'h0, cal_active}, 12'h001);
        wait_lvl(1'b0, n);
        check(in_span(n, CAL_TICKS, 5), 12'h001);
        repeat (2) @(negedge clk);
        check({11'h0, cal_active}, 12'h000);
        mrst = 1'b1;
        repeat (3) @(negedge clk);
        check({10'h0, cal_active, conv_done_n}, 12'h003);
        mrst = 1'b0;
        wait_lvl(1'b0, n);
        check(in_span(n, CAL_TICKS, 5), 12'h001);
        for (int i = 0; i < 4; i++) begin
            pol = i[0];
            sample = i[1] ? 12'hF00 : 12'h123;
            convert(`CONV_TICKS, 5);
            u_host_port_model.bus_read(1'b1, 1'b0, val, oe);
            check(val, enc(pol, sample));
            check({11'h0, oe}, 12'h001);
            check({10'h0, conv_done_n, data_oe}, 12'h002);
        end
        repeat (80) @(negedge clk);
        check({11'h0, track_done_n}, 12'h000);
        u_host_port_model.bus_read(1'b0, 1'b0, val, oe);
        check({6'h00, val[11:8], val[`STS_CAL], val[`STS_BUSY]}, 12'h000);
        check({11'h0, oe}, 12'h001);
        u_host_port_model.bus_read(1'b1, 1'b1, val, oe);
        check({11'h0, oe}, 12'h000);
        wide_bus = 1'b0;
        pol = 1'b1;
        sample = 12'h5A7;
        convert(`CONV_TICKS, 5);
        for (int i = 0; i < 3; i++) begin
            u_host_port_model.bus_read(1'b1, 1'b0, val, oe);
            check(val, i[0] ? 12'h070 : 12'h0DA);
        end
        wide_bus = 1'b1;
        u_host_port_model.cal_request(1'b0, 1'b0);
        u_host_port_model.bus_read(1'b0, 1'b0, val, oe);
        check({11'h0, val[`STS_ILV]}, 12'h001);
        convert(`CONV_TICKS + `ILV_EXTRA_TICKS, 5);
        u_host_port_model.cal_request(1'b0, 1'b1);
        u_host_port_model.bus_read(1'b0, 1'b0, val, oe);
        check({11'h0, val[`STS_ILV]}, 12'h000);
        u_host_port_model.cal_request(1'b1, 1'b1);
        check({11'h0, cal_active}, 12'h001);
        u_host_port_model.strobe_hold();
        repeat (20) @(negedge clk);
        check({10'h0, cal_active, conv_done_n}, 12'h003);
        u_host_port_model.bus_read(1'b0, 1'b0, val, oe);
        check({10'h0, val[`STS_BURST], val[`STS_BUSY]}, 12'h002);
        u_host_port_model.cal_request(1'b0, 1'b1);
        check({11'h0, cal_active}, 12'h000);
        u_host_port_model.soft_reset();
        check({11'h0, cal_active}, 12'h001);
        wait_lvl(1'b0, n);
        check(in_span(n, CAL_TICKS, 5), 12'h001);
        loopback = 1'b1;
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, n);
        wait_lvl(1'b1, n);
        wait_lvl(1'b0, m);
        check(in_span(n + m, `LOOP_TICKS, 5), 12'h001);
        loopback = 1'b0;
        repeat (400) @(negedge clk);
        ext_en = 1'b1;
        repeat (20) @(negedge clk);
        convert(`CONV_TICKS, 4);
        print_verdict();
    end

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        print_verdict();
    end
endmodule : adc_host_control_port_tb
